// *** shared/qss_defines.svh ***
// offsets, field positions and reset values of the serial memory status block
`ifndef QSS_DEFINES_SVH
`define QSS_DEFINES_SVH
`define QSS_STATUS_TWO_OFS 4'h0
`define QSS_EVENT_STAT_OFS 4'h4
`define QSS_EVENT_MASK_OFS 4'h8
`define QSS_PHASE_LSB 16
`define QSS_PHASE_MSB 17
`define QSS_FREE_LSB 7
`define QSS_FREE_MSB 11
`define QSS_LANE_LSB 3
`define QSS_LANE_MSB 6
`define QSS_RECEIVE_UNDERFLOW_FLAG_BIT 1
`define QSS_TRANSMIT_OVERFLOW_FLAG_BIT 0
`define QSS_WORD_RESET 32'h0000_0000
`define QSS_EVT_RESET 2'h0
`endif

// *** shared/qss_pkg.sv ***
// types shared by the serial memory status block
package qss_pkg;
	typedef enum logic [1:0] {
		QSS_PH_IDLE = 2'h0,
		QSS_PH_TX = 2'h1,
		QSS_PH_RX = 2'h2
	} qss_phase_type;
	typedef logic [31:0] qss_word_type;
endpackage

// *** verilog/qss_sticky.sv ***
// one sticky event flag with write-one-to-clear
`timescale 1ns/1ns
module qss_sticky (
	input wire logic clk,
	input wire logic rst,
	input wire logic set,
	input wire logic clr,
	output logic flag
);
	logic flag_r;
	logic flag_nxt;

	// set beats clear so an event in the clear cycle survives
	always_comb begin
		flag_nxt = flag_r;
		if (clr)
			flag_nxt = 1'b0;
		if (set)
			flag_nxt = 1'b1;
	end

	always_ff @(posedge clk) begin
		if (rst)
			flag_r <= 1'b0;
		else
			flag_r <= flag_nxt;
	end

	assign flag = flag_r;
endmodule

// *** verilog/qss_status.sv ***
// status word of the quad serial interface with wishbone slave
//
// Summary of operation
// (RULE1) two-bit phase: idle, transmit, receive; never 11
// (RULE2) five-bit control fifo free byte count
// (RULE3) lane data present bits six to three
// (RULE4) bit one set on receive fifo underflow
// (RULE5) bit zero set on transmit fifo overflow
// (RULE6) unused bit positions always read zero
// (RULE7) writes ignored; fields zero after reset
//
// Local design decisions: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`include "qss_defines.svh"
module qss_status (
	input wire logic MCLK,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output qss_pkg::qss_word_type WB_DAT_O,
	output logic WB_ACK_O,
	input wire qss_pkg::qss_phase_type PHASE_IN,
	input wire logic [4:0] FREE_BYTES_IN,
	input wire logic [3:0] LANE_PRESENT_IN,
	input wire logic RX_UNDERFLOW_EVT,
	input wire logic TX_OVERFLOW_EVT,
	output logic IRQ
);
	import qss_pkg::*;

	// ----------------------------------------------------------------
	// live status capture
	// ----------------------------------------------------------------
	logic [1:0] phase_r, phase_nxt;
	logic [4:0] free_r, free_nxt;
	logic [3:0] lane_r, lane_nxt;
	logic ack_r, ack_nxt;
	logic irq_r, irq_nxt;
	qss_word_type dat_r, dat_nxt;
	logic [1:0] mask_r, mask_nxt;
	logic [1:0] evt;
	logic [1:0] evt_clr;
	logic [1:0] evt_set;
	logic req;
	logic wr_ack;

	// reserved phase code is folded to idle, it must never be shown
	always_comb begin
		phase_nxt = (PHASE_IN == 2'h3) ? 2'h0 : PHASE_IN; // [RULE1]
		free_nxt = FREE_BYTES_IN; // [RULE2]
		lane_nxt = LANE_PRESENT_IN; // [RULE3]
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			phase_r <= 2'h0; // [RULE7]
			free_r <= 5'h00;
			lane_r <= 4'h0;
		end else begin
			phase_r <= phase_nxt;
			free_r <= free_nxt;
			lane_r <= lane_nxt;
		end
	end

	// ----------------------------------------------------------------
	// sticky underflow and overflow flags
	// ----------------------------------------------------------------
	// flags double as interrupt status; write one clears at event reg
	// writes commit at the edge that shows ack, when the master ends
	assign req = WB_CYC_I && WB_STB_I && !ack_r;
	assign wr_ack = WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] &&
		ack_r;
	assign evt_clr = (wr_ack && WB_ADR_I == `QSS_EVENT_STAT_OFS) ?
		WB_DAT_I[1:0] : 2'h0;
	assign evt_set[`QSS_RECEIVE_UNDERFLOW_FLAG_BIT] = RX_UNDERFLOW_EVT; // [RULE4]
	assign evt_set[`QSS_TRANSMIT_OVERFLOW_FLAG_BIT] = TX_OVERFLOW_EVT; // [RULE5]

	// one sticky cell per event bit, same layout as the status word
	for (genvar gi = 0; gi < 2; gi++) begin : g_flag
		qss_sticky u_flag (
			.clk(MCLK),
			.rst(RST),
			.set(evt_set[gi]),
			.clr(evt_clr[gi]),
			.flag(evt[gi])
		);
	end

	// ----------------------------------------------------------------
	// wishbone slave: one registered ack per request, a cycle after the strobe
	// ----------------------------------------------------------------
	function automatic qss_word_type status_word(input logic [1:0] ph,
		input logic [4:0] fr, input logic [3:0] ln, input logic [1:0] ev);
		qss_word_type w;
		w = `QSS_WORD_RESET; // [RULE6]
		w[`QSS_PHASE_MSB:`QSS_PHASE_LSB] = ph;
		w[`QSS_FREE_MSB:`QSS_FREE_LSB] = fr;
		w[`QSS_LANE_MSB:`QSS_LANE_LSB] = ln;
		w[`QSS_RECEIVE_UNDERFLOW_FLAG_BIT] = ev[1];
		w[`QSS_TRANSMIT_OVERFLOW_FLAG_BIT] = ev[0];
		return w;
	endfunction

	// writes to the status word fall through, the ack still comes
	always_comb begin
		ack_nxt = req;
		dat_nxt = dat_r;
		mask_nxt = mask_r;
		if (wr_ack && WB_ADR_I == `QSS_EVENT_MASK_OFS)
			mask_nxt = WB_DAT_I[1:0];
		if (req && !WB_WE_I) begin
			unique case (WB_ADR_I)
			`QSS_STATUS_TWO_OFS:
				dat_nxt = status_word(phase_r, free_r, lane_r, evt); // [RULE7]
			`QSS_EVENT_STAT_OFS:
				dat_nxt = {30'h0, evt};
			`QSS_EVENT_MASK_OFS:
				dat_nxt = {30'h0, mask_r};
			default:
				dat_nxt = `QSS_WORD_RESET;
			endcase
		end
		irq_nxt = |(evt & mask_r);
	end

	always_ff @(posedge MCLK) begin
		if (RST) begin
			ack_r <= 1'b0;
			dat_r <= `QSS_WORD_RESET;
			mask_r <= `QSS_EVT_RESET;
			irq_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
			dat_r <= dat_nxt;
			mask_r <= mask_nxt;
			irq_r <= irq_nxt;
		end
	end

	assign WB_ACK_O = ack_r;
	assign WB_DAT_O = dat_r;
	assign IRQ = irq_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	property p_phase_legal;
		@(posedge MCLK) disable iff (RST)
		ack_r && WB_ADR_I == `QSS_STATUS_TWO_OFS && !WB_WE_I
			|-> WB_DAT_O[17:16] != 2'h3;
	endproperty
	a_phase_legal: assert property (p_phase_legal) // [RULE1]
		else $error("reserved phase code shown");

	property p_free_read;
		@(posedge MCLK) disable iff (RST)
		req && !WB_WE_I && WB_ADR_I == `QSS_STATUS_TWO_OFS
			|=> WB_DAT_O[11:7] == $past(FREE_BYTES_IN, 2);
	endproperty
	a_free_read: assert property (p_free_read) // [RULE2]
		else $error("free byte field wrong");

	property p_lane_read;
		@(posedge MCLK) disable iff (RST)
		req && !WB_WE_I && WB_ADR_I == `QSS_STATUS_TWO_OFS
			|=> WB_DAT_O[6:3] == $past(LANE_PRESENT_IN, 2);
	endproperty
	a_lane_read: assert property (p_lane_read) // [RULE3]
		else $error("lane field wrong");

	property p_receive_underflow_flag_set;
		@(posedge MCLK) disable iff (RST)
		RX_UNDERFLOW_EVT |=> evt[1];
	endproperty
	a_receive_underflow_flag_set: assert property (p_receive_underflow_flag_set) // [RULE4]
		else $error("underflow flag not set");

	property p_transmit_overflow_flag_set;
		@(posedge MCLK) disable iff (RST)
		TX_OVERFLOW_EVT |=> evt[0];
	endproperty
	a_transmit_overflow_flag_set: assert property (p_transmit_overflow_flag_set) // [RULE5]
		else $error("overflow flag not set");

	property p_zero_bits;
		@(posedge MCLK) disable iff (RST)
		req && !WB_WE_I && WB_ADR_I == `QSS_STATUS_TWO_OFS
			|=> WB_DAT_O[31:18] == 14'h0 && WB_DAT_O[15:12] == 4'h0
			&& WB_DAT_O[2] == 1'b0;
	endproperty
	a_zero_bits: assert property (p_zero_bits) // [RULE6]
		else $error("unused bits not zero");

	property p_flag_hold;
		@(posedge MCLK) disable iff (RST)
		evt[0] && !evt_clr[0] |=> evt[0];
	endproperty
	a_flag_hold: assert property (p_flag_hold) // [RULE5]
		else $error("flag lost without clear");

	property p_irq;
		@(posedge MCLK) disable iff (RST)
		##1 IRQ == |($past(evt) & $past(mask_r));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt level wrong");

	property p_ack_once;
		@(posedge MCLK) disable iff (RST)
		WB_ACK_O |=> !WB_ACK_O;
	endproperty
	a_ack_once: assert property (p_ack_once)
		else $error("ack held two cycles");

	property p_ack_answer;
		@(posedge MCLK) disable iff (RST)
		req |=> WB_ACK_O;
	endproperty
	a_ack_answer: assert property (p_ack_answer)
		else $error("request not answered");

	// a flag may only rise on its own event
	property p_receive_underflow_flag_quiet;
		@(posedge MCLK) disable iff (RST)
		!evt[`QSS_RECEIVE_UNDERFLOW_FLAG_BIT] && !RX_UNDERFLOW_EVT |=> !evt[`QSS_RECEIVE_UNDERFLOW_FLAG_BIT];
	endproperty
	a_receive_underflow_flag_quiet: assert property (p_receive_underflow_flag_quiet) // [RULE4]
		else $error("underflow flag set without event");

	property p_transmit_overflow_flag_quiet;
		@(posedge MCLK) disable iff (RST)
		!evt[`QSS_TRANSMIT_OVERFLOW_FLAG_BIT] && !TX_OVERFLOW_EVT |=> !evt[`QSS_TRANSMIT_OVERFLOW_FLAG_BIT];
	endproperty
	a_transmit_overflow_flag_quiet: assert property (p_transmit_overflow_flag_quiet) // [RULE5]
		else $error("overflow flag set without event");

	// a write of one at the acked edge clears unless the event repeats
	property p_receive_underflow_flag_clear;
		@(posedge MCLK) disable iff (RST)
		WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] &&
			WB_ADR_I == `QSS_EVENT_STAT_OFS && WB_DAT_I[1] &&
			!RX_UNDERFLOW_EVT |=> !evt[`QSS_RECEIVE_UNDERFLOW_FLAG_BIT];
	endproperty
	a_receive_underflow_flag_clear: assert property (p_receive_underflow_flag_clear) // [RULE4]
		else $error("underflow flag not cleared");

	property p_transmit_overflow_flag_clear;
		@(posedge MCLK) disable iff (RST)
		WB_ACK_O && WB_CYC_I && WB_STB_I && WB_WE_I && WB_SEL_I[0] &&
			WB_ADR_I == `QSS_EVENT_STAT_OFS && WB_DAT_I[0] &&
			!TX_OVERFLOW_EVT |=> !evt[`QSS_TRANSMIT_OVERFLOW_FLAG_BIT];
	endproperty
	a_transmit_overflow_flag_clear: assert property (p_transmit_overflow_flag_clear) // [RULE5]
		else $error("overflow flag not cleared");
endmodule

// *** testbench/qss_far_model.sv ***
// far-side memory device model driving the block's status inputs
`timescale 1ns/1ns
module qss_far_model (
	input wire logic clk,
	input wire logic [1:0] ph_set,
	input wire logic [4:0] fr_set,
	input wire logic [3:0] ln_set,
	input wire logic [1:0] ev_set,
	output qss_pkg::qss_phase_type phase,
	output logic [4:0] free_bytes,
	output logic [3:0] lanes,
	output logic rx_und,
	output logic tx_ovf
);
	import qss_pkg::*;
	// pins move only just after an edge, as the real engine would
	always_ff @(posedge clk) begin
		phase <= qss_phase_type'(ph_set);
		free_bytes <= fr_set;
		lanes <= ln_set;
		{rx_und, tx_ovf} <= ev_set;
	end
endmodule

// *** testbench/tb_qss_status.sv ***
// register-level bench of the serial memory status block
`timescale 1ns/1ns
`include "qss_defines.svh"
module tb_qss_status;
	import qss_pkg::*;
	logic clk = 0;
	logic rst = 1;
	logic cyc = 0;
	logic we = 0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] sel = 4'hF;
	logic [1:0] ph = 2'h0;
	logic [1:0] ev = 2'h0;
	logic [4:0] fr = 5'h00;
	logic [3:0] ln = 4'h0;
	qss_word_type rd;
	qss_word_type q;
	logic ack;
	logic irq;
	qss_phase_type phase;
	logic [4:0] fb;
	logic [3:0] lp;
	logic ux;
	logic ox;
	int bad_count = 0;
	int n_checks = 0;
	// ----------------------------------------------------------
	// clock, models and tasks
	// ----------------------------------------------------------
	initial forever #5 clk = ~clk;
	qss_far_model FAR (.clk(clk), .ph_set(ph), .fr_set(fr), .ln_set(ln),
		.ev_set(ev), .phase(phase), .free_bytes(fb), .lanes(lp),
		.rx_und(ux), .tx_ovf(ox));
	qss_status DUT (.MCLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
		.WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wd),
		.WB_DAT_O(rd), .WB_ACK_O(ack), .PHASE_IN(phase),
		.FREE_BYTES_IN(fb), .LANE_PRESENT_IN(lp),
		.RX_UNDERFLOW_EVT(ux), .TX_OVERFLOW_EVT(ox), .IRQ(irq));
	task summarize();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	// one classic cycle; the wait is bounded only by the watchdog
	task wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		@(posedge clk);
		cyc <= 1;
		we <= w;
		sel <= s;
		adr <= a;
		wd <= d;
		do @(posedge clk); while (ack !== 1'b1);
		q = rd;
		cyc <= 0;
	endtask
	task rdc(input logic [3:0] a, input logic [31:0] e);
		wb(0, a, 32'h0000_0000);
		chk("read", e, q);
	endtask
	task settle();
		repeat (2) @(posedge clk);
	endtask
	// ----------------------------------------------------------
	// tests
	// ----------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk);
		rst <= 0;
		rdc(`QSS_STATUS_TWO_OFS, `QSS_WORD_RESET);
		rdc(`QSS_EVENT_MASK_OFS, 32'h0000_0000);
		// every phase code, one lane at a time, reserved phase last
		for (int i = 0; i < 4; i++) begin
			ph <= 2'(i);
			fr <= 5'h1F >> i;
			ln <= 4'h1 << i;
			settle();
			rdc(`QSS_STATUS_TWO_OFS, {14'h0, (i == 3) ? 2'h0 : 2'(i), 4'h0,
				5'h1F >> i, 4'h1 << i, 3'h0});
		end
		wb(1, `QSS_STATUS_TWO_OFS, 32'hFFFF_FFFF);
		rdc(`QSS_STATUS_TWO_OFS, 32'h0000_01C0);
		$display("field test done");
		ph <= 2'h0;
		fr <= 5'h00;
		ln <= 4'h0;
		ev <= 2'h2;
		@(posedge clk);
		ev <= 2'h0;
		settle();
		rdc(`QSS_STATUS_TWO_OFS, 32'h0000_0002);
		rdc(`QSS_EVENT_STAT_OFS, 32'h0000_0002);
		chk("irq masked", 1'b0, irq);
		wb(1, `QSS_EVENT_MASK_OFS, 32'h0000_0003);
		rdc(`QSS_EVENT_MASK_OFS, 32'h0000_0003);
		// byte lane zero not selected: the mask write must not land
		wb(1, `QSS_EVENT_MASK_OFS, 32'h0000_0000, 4'hE);
		rdc(`QSS_EVENT_MASK_OFS, 32'h0000_0003);
		settle();
		chk("irq on", 1'b1, irq);
		wb(1, `QSS_EVENT_STAT_OFS, 32'h0000_0002);
		ev <= 2'h1;
		@(posedge clk);
		ev <= 2'h0;
		settle();
		rdc(`QSS_STATUS_TWO_OFS, 32'h0000_0001);
		rdc(`QSS_EVENT_STAT_OFS, 32'h0000_0001);
		chk("irq tx", 1'b1, irq);
		wb(1, `QSS_EVENT_STAT_OFS, 32'h0000_0001);
		settle();
		chk("irq off", 1'b0, irq);
		rdc(`QSS_STATUS_TWO_OFS, 32'h0000_0000);
		rdc(4'hC, 32'h0000_0000);
		$display("event test done");
		summarize();
	end
	// watchdog well past the fewer than one hundred cycles the tests take
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		summarize();
	end
endmodule
